// ===== hw/omb_pkg.sv
// package of constants for the operating mode bus configuration block
package omb_pkg;
	// ------------------------------------------------------------
	// register offsets (byte addresses on apb)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_P2_DDR   = 8'h00;
	localparam logic [7:0] ADDR_P2_DATA  = 8'h04;
	localparam logic [7:0] ADDR_P3_DDR   = 8'h08;
	localparam logic [7:0] ADDR_P4_DDR   = 8'h0C;
	localparam logic [7:0] ADDR_P3_DATA  = 8'h10;
	localparam logic [7:0] ADDR_P4_DATA  = 8'h14;
	localparam logic [7:0] ADDR_MEM_CTL  = 8'h18;
	localparam logic [7:0] ADDR_STATUS   = 8'h1C;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int MODE_FIELD_LSB   = 5;
	localparam int MODE_SWITCH_BIT  = 5;
	localparam int EPROM_CTL_LSB    = 0;
	// ------------------------------------------------------------
	// reset values and fixed figures
	// ------------------------------------------------------------
	localparam logic [7:0] DDR_RESET  = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [1:0] EPROM_CTL_RESET = 2'h0;
	localparam int MODE_PINS   = 18;
	localparam int COMMON_PINS = 22;
	localparam logic [2:0] MODE_PROG   = 3'h0;
	localparam logic [2:0] MODE_NORAM  = 3'h3;
	localparam logic [2:0] MODE_RAMONLY = 3'h2;
	localparam logic [2:0] MODE_TEST   = 3'h4;
	localparam logic [2:0] MODE_NMUX   = 3'h5;
	localparam logic [2:0] MODE_SINGLE = 3'h7;
	localparam logic [15:0] VEC_NORMAL = 16'hFFF0;
	localparam logic [15:0] VEC_PROG   = 16'hBFF0;
	localparam logic [15:0] VEC_TEST   = 16'h00F0;
	localparam logic [15:0] EXT_NMUX_BASE = 16'h0100;
	// ------------------------------------------------------------
	// bus styles
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		BUS_SINGLE,
		BUS_NMUX,
		BUS_MUX
	} bus_style_type;
	// strobe pin roles
	typedef enum logic [2:0] {
		STB_PORT3_INPUT,
		STB_PORT3_OUTPUT,
		STB_EXTERNAL_IO_SELECT,
		STB_ADDRESS_LATCH,
		STB_READ_WRITE
	} strobe_role_type;
endpackage

// ===== hw/omb_top.sv
// operating mode capture and mode-dependent bus configuration
// Function
// - eight modes set map, ports, vectors
// - modes 4,7 single; 5 nonmux; rest mux
// - mode shapes 18 pins, 22 fixed
// - write-only direction registers, readable data registers
// - single-chip: all ports are plain i/o
// - mode 7: input/output strobes, ram+eprom
// - mode 4 bit5 write enters mode 5
// - mode 5: port 3 data bus, 256 bytes
// - mode 5: port 4 input/address, io select
// - mux modes: port3 addr/data, latch strobe
// - ram/eprom presence follows the mode
// - mode 0: vectors at bff0, eprom programmable
// - two mode 0 eprom control bits
// - mode pins latched at reset release
// - mode number equals latched pin levels
// - mux: address at strobe fall, data e-high
// - mode 6 port 4 per-bit address outputs
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module omb_top (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// mode select pins
	input  wire logic        mode_select_pin_high,
	input  wire logic        mode_select_pin_mid,
	input  wire logic        mode_select_pin_low,
	// configuration outputs
	output logic [2:0]       mode_out,
	output logic [1:0]       bus_style,
	output logic [2:0]       strobe_ctl_first_role,
	output logic [2:0]       strobe_ctl_second_role,
	output logic             ram_internal,
	output logic             ram_page_alias,
	output logic             eprom_internal,
	output logic             eprom_prog_enable,
	output logic [15:0]      vector_base,
	output logic             vectors_external,
	output logic [7:0]       port3_oe,
	output logic [7:0]       port4_addr_sel,
	output logic             port3_mux_addr_data,
	output logic             ext_drive_e_high_only
);
	// ------------------------------------------------------------
	// pin synchronisers and reset-release capture
	// ------------------------------------------------------------
	logic [2:0] pin_s1_ff, pin_s2_ff;
	logic       captured_ff, nxt_captured;
	logic [2:0] mode_ff, nxt_mode;
	logic [7:0] p2_ddr_ff, nxt_p2_ddr;
	logic [7:0] p2_dat_ff, nxt_p2_dat;
	logic [7:0] p3_ddr_ff, nxt_p3_ddr;
	logic [7:0] p4_ddr_ff, nxt_p4_ddr;
	logic [7:0] p3_dat_ff, nxt_p3_dat;
	logic [7:0] p4_dat_ff, nxt_p4_dat;
	logic [1:0] epc_ff, nxt_epc;
	logic       rdy_ff, nxt_rdy;
	logic [31:0] rd_ff, nxt_rd;
	logic       err_ff, nxt_err;

	// no reset on these two stages: the pins must be sampled while reset is
	// still held, because the mode is taken at the first edge after release
	always_ff @(posedge mclk) begin
		pin_s1_ff <= {mode_select_pin_high, mode_select_pin_mid, mode_select_pin_low};
		pin_s2_ff <= pin_s1_ff;
	end

	// ------------------------------------------------------------
	// mode decode helper
	// ------------------------------------------------------------
	function automatic omb_pkg::bus_style_type style_of(input logic [2:0] m);
		if (m == omb_pkg::MODE_TEST || m == omb_pkg::MODE_SINGLE)
			return omb_pkg::BUS_SINGLE;
		else if (m == omb_pkg::MODE_NMUX)
			return omb_pkg::BUS_NMUX;
		else
			return omb_pkg::BUS_MUX;
	endfunction

	// ------------------------------------------------------------
	// register file and mode next state
	// ------------------------------------------------------------
	logic wr_take, rd_take;
	// a write lands only at the edge that completes the transfer
	assign wr_take = psel && penable && pwrite && rdy_ff;
	assign rd_take = psel && !penable;

	always_comb begin
		nxt_captured = 1'b1;
		nxt_mode     = mode_ff;
		nxt_p2_ddr   = p2_ddr_ff;
		nxt_p2_dat   = p2_dat_ff;
		nxt_p3_ddr   = p3_ddr_ff;
		nxt_p4_ddr   = p4_ddr_ff;
		nxt_p3_dat   = p3_dat_ff;
		nxt_p4_dat   = p4_dat_ff;
		nxt_epc      = epc_ff;
		nxt_rdy      = psel && penable && !rdy_ff;
		nxt_rd       = rd_ff;
		nxt_err      = 1'b0;
		// levels sampled after synchronising, once after release
		if (!captured_ff)
			nxt_mode = pin_s2_ff;
		if (wr_take) begin
			unique case (paddr)
				omb_pkg::ADDR_P2_DDR:  nxt_p2_ddr = pwdata[7:0];
				omb_pkg::ADDR_P2_DATA: begin
					nxt_p2_dat = pwdata[7:0];
					// only the test mode may leave its mode, and only to 5
					if (mode_ff == omb_pkg::MODE_TEST && pwdata[omb_pkg::MODE_SWITCH_BIT])
						nxt_mode = omb_pkg::MODE_NMUX;
				end
				omb_pkg::ADDR_P3_DDR:  nxt_p3_ddr = pwdata[7:0];
				omb_pkg::ADDR_P4_DDR:  nxt_p4_ddr = pwdata[7:0];
				omb_pkg::ADDR_P3_DATA: nxt_p3_dat = pwdata[7:0];
				omb_pkg::ADDR_P4_DATA: nxt_p4_dat = pwdata[7:0];
				omb_pkg::ADDR_MEM_CTL: nxt_epc = pwdata[omb_pkg::EPROM_CTL_LSB +: 2];
				default:               ;
			endcase
		end
		// unmapped writes are refused in the first access cycle so pslverr meets pready
		if (psel && penable && !rdy_ff && pwrite) begin
			unique case (paddr)
				omb_pkg::ADDR_P2_DDR, omb_pkg::ADDR_P2_DATA, omb_pkg::ADDR_P3_DDR,
				omb_pkg::ADDR_P4_DDR, omb_pkg::ADDR_P3_DATA, omb_pkg::ADDR_P4_DATA,
				omb_pkg::ADDR_MEM_CTL: ;
				default:               nxt_err = 1'b1;
			endcase
		end
		if (psel && penable && !rdy_ff && !pwrite) begin
			nxt_rd = 32'h0;
			unique case (paddr)
				// direction registers are write-only and read zero
				omb_pkg::ADDR_P2_DDR, omb_pkg::ADDR_P3_DDR,
				omb_pkg::ADDR_P4_DDR:  nxt_rd = 32'h0;
				omb_pkg::ADDR_P2_DATA: nxt_rd = {24'h0, mode_ff, p2_dat_ff[4:0]};
				omb_pkg::ADDR_P3_DATA: nxt_rd = {24'h0, p3_dat_ff};
				omb_pkg::ADDR_P4_DATA: nxt_rd = {24'h0, p4_dat_ff};
				omb_pkg::ADDR_MEM_CTL: nxt_rd = {30'h0, epc_ff};
				omb_pkg::ADDR_STATUS:  nxt_rd = {27'h0, style_of(mode_ff), mode_ff};
				default:               nxt_err = 1'b1;
			endcase
		end
		if (rd_take)
			nxt_err = 1'b0;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			captured_ff <= 1'b0;
			mode_ff     <= 3'h0;
			p2_ddr_ff   <= omb_pkg::DDR_RESET;
			p2_dat_ff   <= omb_pkg::DATA_RESET;
			p3_ddr_ff   <= omb_pkg::DDR_RESET;
			p4_ddr_ff   <= omb_pkg::DDR_RESET;
			p3_dat_ff   <= omb_pkg::DATA_RESET;
			p4_dat_ff   <= omb_pkg::DATA_RESET;
			epc_ff      <= omb_pkg::EPROM_CTL_RESET;
			rdy_ff      <= 1'b0;
			rd_ff       <= 32'h0;
			err_ff      <= 1'b0;
		end else begin
			captured_ff <= nxt_captured;
			mode_ff     <= nxt_mode;
			p2_ddr_ff   <= nxt_p2_ddr;
			p2_dat_ff   <= nxt_p2_dat;
			p3_ddr_ff   <= nxt_p3_ddr;
			p4_ddr_ff   <= nxt_p4_ddr;
			p3_dat_ff   <= nxt_p3_dat;
			p4_dat_ff   <= nxt_p4_dat;
			epc_ff      <= nxt_epc;
			rdy_ff      <= nxt_rdy;
			rd_ff       <= nxt_rd;
			err_ff      <= nxt_err;
		end
	end

	// ------------------------------------------------------------
	// mode-dependent configuration, registered
	// ------------------------------------------------------------
	logic [2:0]  mo_ff, nxt_mo;
	logic [1:0]  bs_ff, nxt_bs;
	logic [2:0]  s1_ff, nxt_s1;
	logic [2:0]  s2_ff, nxt_s2;
	logic        ri_ff, nxt_ri, ra_ff, nxt_ra, ei_ff, nxt_ei, ep_ff, nxt_ep;
	logic [15:0] vb_ff, nxt_vb;
	logic        ve_ff, nxt_ve;
	logic [7:0]  p3oe_ff, nxt_p3oe;
	logic [7:0]  p4a_ff, nxt_p4a;
	logic        mx_ff, nxt_mx, eh_ff, nxt_eh;

	always_comb begin
		nxt_mo   = mode_ff;
		nxt_bs   = style_of(mode_ff);
		nxt_ri   = 1'b1;
		nxt_ra   = 1'b0;
		nxt_ei   = 1'b1;
		nxt_ep   = 1'b0;
		nxt_vb   = omb_pkg::VEC_NORMAL;
		nxt_ve   = 1'b1;
		nxt_p3oe = 8'h00;
		nxt_p4a  = 8'h00;
		nxt_mx   = 1'b0;
		nxt_eh   = 1'b0;
		nxt_s1   = omb_pkg::STB_ADDRESS_LATCH;
		nxt_s2   = omb_pkg::STB_READ_WRITE;
		unique case (style_of(mode_ff))
			omb_pkg::BUS_SINGLE: begin
				// ports stay plain i/o under their direction registers
				nxt_p3oe = p3_ddr_ff;
				nxt_ve   = 1'b0;
				nxt_s1   = omb_pkg::STB_PORT3_INPUT;
				nxt_s2   = omb_pkg::STB_PORT3_OUTPUT;
			end
			omb_pkg::BUS_NMUX: begin
				nxt_ve  = 1'b0;
				nxt_p4a = p4_ddr_ff;
				nxt_s1  = omb_pkg::STB_EXTERNAL_IO_SELECT;
				nxt_eh  = 1'b1;
			end
			omb_pkg::BUS_MUX: begin
				nxt_mx  = 1'b1;
				nxt_eh  = 1'b1;
				nxt_p4a = 8'hFF;
			end
			default: ;
		endcase
		unique case (mode_ff)
			omb_pkg::MODE_TEST: begin
				nxt_ei = 1'b0;
				nxt_ra = 1'b1;
				nxt_vb = omb_pkg::VEC_TEST;
			end
			omb_pkg::MODE_NORAM: begin
				nxt_ri = 1'b0;
				nxt_ei = 1'b0;
			end
			omb_pkg::MODE_RAMONLY: nxt_ei = 1'b0;
			3'h6: begin
				// partial decode: a port 4 bit carries address only once software asks
				nxt_p4a = p4_ddr_ff;
				// vectors stay on chip in this mode
				nxt_ve  = 1'b0;
			end
			omb_pkg::MODE_PROG: begin
				nxt_vb = omb_pkg::VEC_PROG;
				nxt_ep = 1'b1;
			end
			default: ;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mo_ff <= 3'h0; bs_ff <= 2'h0; s1_ff <= 3'h0; s2_ff <= 3'h0;
			ri_ff <= 1'b0; ra_ff <= 1'b0; ei_ff <= 1'b0; ep_ff <= 1'b0;
			vb_ff <= 16'h0; ve_ff <= 1'b0; p3oe_ff <= 8'h00; p4a_ff <= 8'h00;
			mx_ff <= 1'b0; eh_ff <= 1'b0;
		end else begin
			mo_ff <= nxt_mo; bs_ff <= nxt_bs; s1_ff <= nxt_s1; s2_ff <= nxt_s2;
			ri_ff <= nxt_ri; ra_ff <= nxt_ra; ei_ff <= nxt_ei; ep_ff <= nxt_ep;
			vb_ff <= nxt_vb; ve_ff <= nxt_ve; p3oe_ff <= nxt_p3oe; p4a_ff <= nxt_p4a;
			mx_ff <= nxt_mx; eh_ff <= nxt_eh;
		end
	end

	// ------------------------------------------------------------
	// outputs, each straight from its flop
	// ------------------------------------------------------------
	assign pready   = rdy_ff;
	assign prdata   = rd_ff;
	assign pslverr  = err_ff;
	assign mode_out = mo_ff;
	assign bus_style = bs_ff;
	assign strobe_ctl_first_role  = s1_ff;
	assign strobe_ctl_second_role = s2_ff;
	assign ram_internal      = ri_ff;
	assign ram_page_alias    = ra_ff;
	assign eprom_internal    = ei_ff;
	assign eprom_prog_enable = ep_ff;
	assign vector_base       = vb_ff;
	assign vectors_external  = ve_ff;
	assign port3_oe          = p3oe_ff;
	assign port4_addr_sel    = p4a_ff;
	assign port3_mux_addr_data   = mx_ff;
	assign ext_drive_e_high_only = eh_ff;
endmodule

// ===== sim/omb_mode_strap.sv
// model of the board circuit that straps the mode pins through reset
`timescale 1ns/100ps
module omb_mode_strap (
	// clock and reset
	input wire logic       mclk,
	input wire logic       rstn,
	// mode to strap
	input wire logic [2:0] mode_req,
	// mode select pins
	output logic           pin_high,
	output logic           pin_mid,
	output logic           pin_low
);
	logic [1:0] hold_ff, nxt_hold;
	always_comb begin
		nxt_hold = (hold_ff == 2'h3) ? hold_ff : hold_ff + 2'h1;
		// after the hold the pins serve other uses: inverse so no stale level passes
		{pin_high, pin_mid, pin_low} = (hold_ff < 2'h2) ? mode_req : ~mode_req;
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hold_ff <= 2'h0;
		end else begin
			hold_ff <= nxt_hold;
		end
	end
endmodule

// ===== sim/omb_properties.sv
// checker of the mode-dependent configuration outputs
`timescale 1ns/100ps
module omb_properties (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rstn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// configuration
	input wire logic [2:0]  mode_out,
	input wire logic [1:0]  bus_style,
	input wire logic [2:0]  strobe_ctl_first_role,
	input wire logic [2:0]  strobe_ctl_second_role,
	input wire logic        ram_internal,
	input wire logic        ram_page_alias,
	input wire logic        eprom_internal,
	input wire logic        eprom_prog_enable,
	input wire logic [15:0] vector_base,
	input wire logic        vectors_external,
	input wire logic        port3_mux_addr_data
);
	// ----------------------------------------------------------
	// helper state
	// ----------------------------------------------------------
	logic [1:0] up_ff, nxt_up;
	logic       live, single, mux;
	// outputs settle two edges after release, so wait three
	always_comb begin
		nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			up_ff <= 2'h0;
		end else begin
			up_ff <= nxt_up;
		end
	end
	// every configuration output is registered in step with mode_out
	assign live   = (up_ff == 2'h3);
	assign single = (mode_out == 3'h4) || (mode_out == 3'h7);
	assign mux    = !single && (mode_out != 3'h5);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	property p_style;
		live |-> bus_style == (single ? 2'h0 : (mux ? 2'h2 : 2'h1));
	endproperty
	a_style: assert property (p_style) else $error("bus style wrong for mode");
	property p_mode7;
		live && mode_out == 3'h7 |-> strobe_ctl_first_role == 3'h0
			&& strobe_ctl_second_role == 3'h1;
	endproperty
	a_mode7: assert property (p_mode7) else $error("mode 7 strobe roles wrong");
	property p_nmux;
		live && mode_out == 3'h5 |-> strobe_ctl_first_role == 3'h2
			&& strobe_ctl_second_role == 3'h4;
	endproperty
	a_nmux: assert property (p_nmux) else $error("mode 5 strobe roles wrong");
	property p_mux;
		live && mux |-> strobe_ctl_first_role == 3'h3 && strobe_ctl_second_role == 3'h4
			&& port3_mux_addr_data;
	endproperty
	a_mux: assert property (p_mux) else $error("multiplexed mode pins wrong");
	property p_test;
		live && mode_out == 3'h4 |-> ram_page_alias && ram_internal && !eprom_internal;
	endproperty
	a_test: assert property (p_test) else $error("mode 4 memory map wrong");
	property p_mem;
		live && (mode_out == 3'h3 || mode_out == 3'h2) |-> !eprom_internal
			&& ram_internal == (mode_out == 3'h2);
	endproperty
	a_mem: assert property (p_mem) else $error("internal memory presence wrong");
	property p_prog;
		live && mode_out == 3'h0 |-> vector_base == 16'hBFF0 && vectors_external
			&& eprom_prog_enable && eprom_internal && ram_internal;
	endproperty
	a_prog: assert property (p_prog) else $error("mode 0 setup wrong");
	property p_hold;
		live && $changed(mode_out) |-> $past(mode_out) == 3'h4 && mode_out == 3'h5;
	endproperty
	a_hold: assert property (p_hold) else $error("mode changed without cause");
	property p_switch;
		live && psel && penable && pready && pwrite && paddr == omb_pkg::ADDR_P2_DATA
			&& pwdata[5] && mode_out == 3'h4 |-> ##[1:2] mode_out == 3'h5;
	endproperty
	a_switch: assert property (p_switch) else $error("mode 4 to 5 switch missing");
endmodule
bind omb_top omb_properties u_props (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .mode_out(mode_out),
	.bus_style(bus_style), .strobe_ctl_first_role(strobe_ctl_first_role),
	.strobe_ctl_second_role(strobe_ctl_second_role), .ram_internal(ram_internal),
	.ram_page_alias(ram_page_alias), .eprom_internal(eprom_internal),
	.eprom_prog_enable(eprom_prog_enable), .vector_base(vector_base),
	.vectors_external(vectors_external), .port3_mux_addr_data(port3_mux_addr_data));

// ===== sim/tb_top.sv
// testbench: mode capture and configuration in every mode
`timescale 1ns/100ps
module tb_top;
	logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr, p3oe, p4sel;
	logic [31:0] pwdata, prdata, rd;
	logic        sel_h, sel_m, sel_l, ram_i, alias_o, epr_i, epr_p, vext, mux_o, sc, mx, eh;
	logic [2:0]  mode_out, mode_req, role1, role2;
	logic [1:0]  bus_style, style;
	logic [15:0] vbase;
	int          bad_count, comparisons, cycles;
	omb_top u_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.mode_select_pin_high(sel_h), .mode_select_pin_mid(sel_m), .mode_select_pin_low(sel_l),
		.mode_out(mode_out), .bus_style(bus_style), .strobe_ctl_first_role(role1),
		.strobe_ctl_second_role(role2), .ram_internal(ram_i), .ram_page_alias(alias_o),
		.eprom_internal(epr_i), .eprom_prog_enable(epr_p), .vector_base(vbase),
		.vectors_external(vext), .port3_oe(p3oe), .port4_addr_sel(p4sel),
		.port3_mux_addr_data(mux_o), .ext_drive_e_high_only(eh));
	omb_mode_strap u_strap (.mclk(mclk), .rstn(rstn), .mode_req(mode_req), .pin_high(sel_h),
		.pin_mid(sel_m), .pin_low(sel_l));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// holds the request until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata, mode_req} = '0;
		{bad_count, comparisons, cycles} = '0;
		for (int m = 0; m < 8; m++) begin
			mode_req <= m[2:0];
			rstn <= 1'b0;
			repeat (4) @(posedge mclk);
			rstn <= 1'b1;
			repeat (3) @(posedge mclk);
			sc = (m == 4) || (m == 7);
			mx = !sc && (m != 5);
			style = sc ? 2'h0 : (mx ? 2'h2 : 2'h1);
			apb(1'b0, omb_pkg::ADDR_STATUS, 32'h0);
			chk(rd, {27'h0, style, m[2:0]});
			apb(1'b0, omb_pkg::ADDR_P2_DATA, 32'h0);
			chk({29'h0, rd[7:5]}, {29'h0, m[2:0]});
			chk({16'h0, vbase}, {16'h0, m == 0 ? 16'hBFF0 : m == 4 ? omb_pkg::VEC_TEST : 16'hFFF0});
			chk({28'h0, ram_i, epr_i, vext, mux_o}, {28'h0, m != 3, m < 2 || m > 4, m < 4, mx});
			chk({29'h0, epr_p, alias_o, eh}, {29'h0, m == 0, m == 4, !sc});
			if (m != 4) chk({26'h0, role1, role2}, sc ? 32'h1 : (mx ? 32'h1C : 32'h14));
			apb(1'b1, omb_pkg::ADDR_P4_DDR, 32'hA5);
			apb(1'b1, omb_pkg::ADDR_P3_DDR, 32'h3C);
			apb(1'b0, omb_pkg::ADDR_P4_DDR, 32'h0);
			chk(rd, 32'h0);
			repeat (3) @(posedge mclk);
			chk({24'h0, p4sel}, m < 4 ? 32'hFF : (m == 5 || m == 6) ? 32'hA5 : 32'h0);
			chk({24'h0, p3oe}, sc ? 32'h3C : 32'h0);
			apb(1'b1, omb_pkg::ADDR_MEM_CTL, 32'h3);
			apb(1'b0, omb_pkg::ADDR_MEM_CTL, 32'h0);
			chk({30'h0, rd[1:0]}, 32'h3);
			apb(1'b1, 8'h40, 32'hFF);
			chk({31'h0, er}, 32'h1);
			apb(1'b1, omb_pkg::ADDR_P2_DATA, 32'h20);
			repeat (3) @(posedge mclk);
			chk({29'h0, mode_out}, m == 4 ? 32'h5 : m);
			chk({30'h0, bus_style}, m == 4 ? 32'h1 : {30'h0, style});
		end
		tally_and_finish();
	end
endmodule
